// File: src/pmws_defines.svh
// Register offsets, field positions, reset values and start-up counts for the power mode sequencer.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef PMWS_DEFINES_SVH
`define PMWS_DEFINES_SVH

// Register byte offsets
`define PMWS_MODE_ADDR      12'h000
`define PMWS_WDCTL_ADDR     12'h004
`define PMWS_STAT_ADDR      12'h008

// Mode control register fields
`define PMWS_HCLK_BIT       0
`define PMWS_IDLE_BIT       1
`define PMWS_HRDY_BIT       2
`define PMWS_LRDY_BIT       3
`define PMWS_FAST_BIT       4
`define PMWS_DIV_LSB        5
`define PMWS_DIV_MSB        7
`define PMWS_MODE_RESET     8'h03

// Watchdog control register fields
`define PMWS_KEEP_BIT       0
`define PMWS_WDEN_BIT       1
`define PMWS_VDEN_BIT       2
`define PMWS_WDCTL_RESET    8'h00

// Status register fields
`define PMWS_PD_BIT         0
`define PMWS_TOF_BIT        1
`define PMWS_STATE_LSB      4
`define PMWS_STATE_MSB      6

// Oscillator start-up counts, in oscillator ticks
`define PMWS_XTAL_START     11'h400
`define PMWS_RC_START       11'h010
`define PMWS_LOW_RC_START   11'h002
`define PMWS_SHORT_START    11'h002
`define PMWS_FAST_SUB_TICKS 2'h2

`endif

// File: src/pmws_pkg.sv
// Types shared by the power mode sequencer.
// Assumes pmws_defines.svh carries the numeric constants.
package pmws_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        PMWS_RUN, PMWS_IDLE_STOP, PMWS_IDLE_RUN, PMWS_SLEEP_DEEP, PMWS_SLEEP_SUB, PMWS_WAKE, PMWS_FSTART, PMWS_FAST
    } pmws_state_t;
    // High-speed oscillator kind, fixed by configuration
    typedef enum logic [1:0] {PMWS_HOSC_XTAL, PMWS_HOSC_EXT_RC, PMWS_HOSC_INT_RC} pmws_hosc_t;
    // System clock source
    typedef enum logic {PMWS_SRC_HIGH, PMWS_SRC_LOW} pmws_src_t;
endpackage : pmws_pkg

// File: src/pmws_top.sv
// Power mode, clock switching and wake-up sequencer with an APB register port.
// Assumes oscillator ticks and the wake pin are asynchronous; core requests are on pclk.
// Functional notes
// - Fast wake only from sub-clock sleep or stopped idle
// - Deep sleep wake ignores fast wake enable
// - Crystal fast wake: sub clock, then crystal after 1024; the code uses 2 ticks after stopped idle
// - RC oscillators wake in 15-16, low RC 1-2; the code uses 2 ticks for the high RC after stopped idle
// - Watchdog off means no fast wake from deep sleep
// - Halt picks idle or sleep; run mode by selects
// - Low clock chosen stops high oscillator and dividers
// - Low-speed run needs stable low oscillator flag
// - Deep sleep needs watchdog and detector both off
// - Deep sleep stops clocks, clears and halts watchdog
// - Sleep halts program, retains memory, registers, ports
// - Sleep entry sets power-down flag, clears timeout flag
// - Sub-clock sleep when watchdog or detector enabled
// - Sub-clock sleep stops system and time base clocks
// - Sub-clock sleep clears then restarts sub-clocked watchdog
// - Idle select with keep bit picks running idle
// - Detector enabled blocks deep sleep
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pmws_defines.svh"

module pmws_top #(
    parameter pmws_pkg::pmws_hosc_t HIGH_OSC     = pmws_pkg::PMWS_HOSC_XTAL,
    parameter bit                   LOW_IS_XTAL  = 1'b0,
    parameter bit                   WDT_FROM_SUB = 1'b1,
    parameter int                   ADDR_W       = 12
) (
    // APB clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                pwdata,
    output var  logic [31:0]                prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    // Core events on pclk
    input  wire logic                       halt_req,
    input  wire logic                       wdt_clear_req,
    input  wire logic                       wdt_timeout,
    // Asynchronous inputs
    input  wire logic                       wake_pin,
    input  wire logic                       high_osc_tick,
    input  wire logic                       low_osc_tick,
    // Oscillator and clock controls
    output var  logic                       high_osc_en,
    output var  logic                       low_osc_en,
    output var  pmws_pkg::pmws_src_t        clk_src,
    output var  logic [2:0]                 clk_div,
    output var  logic                       sys_clk_gate,
    output var  logic                       periph_div_clk_en,
    output var  logic                       time_base_clk_en,
    // Watchdog and core controls
    output var  logic                       wdt_run,
    output var  logic                       wdt_clear,
    output var  logic                       cpu_halt,
    output var  pmws_pkg::pmws_state_t      pwr_state
);
    import pmws_pkg::*;

    // Refuse an address bus too narrow for the register map
    if (ADDR_W < 4) begin : g_bad_addr
        $error("pmws_top: ADDR_W must be at least 4");
    end

    // Registers and state
    logic [7:0]  mode_reg;
    logic [7:0]  wdctl_reg;
    logic        high_rdy;
    logic        low_rdy;
    logic        pd_flag;
    logic        tof;
    logic        short_start;
    logic [10:0] high_cnt;
    logic [10:0] low_cnt;
    logic [1:0]  fast_cnt;
    logic [1:0]  tick_s1;
    logic [1:0]  tick_s2;
    logic [1:0]  tick_d;
    logic        wake_s1;
    logic        wake_s2;
    pmws_state_t state;
    pmws_state_t next_state;

    // Edge of each synchronised oscillator tick; only the second stage is examined
    wire [1:0] tick_edge = tick_s2 & ~tick_d;
    wire       high_tick = tick_edge[0];
    wire       low_tick  = tick_edge[1];

    // Mode control and watchdog control fields
    wire [2:0] div_field = mode_reg[`PMWS_DIV_MSB:`PMWS_DIV_LSB];
    wire       hclk_sel  = mode_reg[`PMWS_HCLK_BIT];
    wire       idle_sel  = mode_reg[`PMWS_IDLE_BIT];
    wire       fast_en   = mode_reg[`PMWS_FAST_BIT];
    wire       keep_clk  = wdctl_reg[`PMWS_KEEP_BIT];
    wire       wdt_en    = wdctl_reg[`PMWS_WDEN_BIT];
    wire       vd_en     = wdctl_reg[`PMWS_VDEN_BIT];

    // Run mode decode: selects 000 and 001 pick the low clock
    wire       want_low  = !hclk_sel && (div_field[2:1] == 2'b00);
    wire [2:0] want_div  = hclk_sel ? 3'h0 : div_field;

    // Halt target mode
    wire         deep_ok   = !wdt_en && !vd_en;
    pmws_state_t halt_mode;
    assign halt_mode = idle_sel ? (keep_clk ? PMWS_IDLE_RUN : PMWS_IDLE_STOP)
                                : (deep_ok ? PMWS_SLEEP_DEEP : PMWS_SLEEP_SUB);
    wire halt_take = halt_req && (state == PMWS_RUN);

    // Fast wake: crystal system clock, enable set, sub clock alive and only from sub-clock sleep or stopped idle
    wire fast_ok = fast_en && (HIGH_OSC == PMWS_HOSC_XTAL) && !want_low && low_rdy
                   && ((state == PMWS_SLEEP_SUB) || (state == PMWS_IDLE_STOP));

    wire asleep  = (state == PMWS_IDLE_STOP) || (state == PMWS_IDLE_RUN)
                   || (state == PMWS_SLEEP_DEEP) || (state == PMWS_SLEEP_SUB);
    wire sys_rdy = want_low ? low_rdy : high_rdy;

    // Start-up thresholds; a restart from idle is short, high RC kinds need 16, low RC 2, crystals 1024
    wire [10:0] high_limit = short_start ? `PMWS_SHORT_START :
                             (HIGH_OSC == PMWS_HOSC_XTAL) ? `PMWS_XTAL_START : `PMWS_RC_START;
    wire [10:0] low_limit  = short_start ? `PMWS_SHORT_START :
                             LOW_IS_XTAL ? `PMWS_XTAL_START : `PMWS_LOW_RC_START;

    // Oscillator demand per state; the high oscillator stays on until the select has left it,
    // so the core never stalls on a stopped clock while the low oscillator is still settling
    wire need_high = ((state == PMWS_RUN) && (!want_low || (clk_src == PMWS_SRC_HIGH)))
                     || (state == PMWS_FAST) || (state == PMWS_FSTART)
                     || (((state == PMWS_WAKE) || (state == PMWS_IDLE_RUN)) && !want_low);
    wire need_low  = (state != PMWS_SLEEP_DEEP)
                     && !((state == PMWS_SLEEP_SUB) && deep_ok);

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            PMWS_RUN:    if (halt_take) next_state = halt_mode;
            PMWS_IDLE_STOP, PMWS_IDLE_RUN, PMWS_SLEEP_DEEP, PMWS_SLEEP_SUB:
                if (wake_s2) next_state = fast_ok ? PMWS_FSTART : PMWS_WAKE;
            PMWS_WAKE:   if (sys_rdy) next_state = PMWS_RUN;
            PMWS_FSTART: if (fast_cnt == `PMWS_FAST_SUB_TICKS) next_state = PMWS_FAST;
            PMWS_FAST:   if (high_rdy) next_state = PMWS_RUN;
        endcase
    end

    // Clock selection target; the low clock is taken only once it is stable
    pmws_src_t tgt_src;
    assign tgt_src = (state == PMWS_FAST) ? PMWS_SRC_LOW :
                     (want_low && (low_rdy || clk_src == PMWS_SRC_LOW)) ? PMWS_SRC_LOW
                     : (want_low ? clk_src : PMWS_SRC_HIGH);
    wire [2:0] tgt_div  = (state == PMWS_FAST) ? 3'h0 : want_div;
    wire       clk_move = (tgt_src != clk_src) || (tgt_div != clk_div);
    wire       clk_on   = (state == PMWS_RUN) || (state == PMWS_FAST) || (state == PMWS_IDLE_RUN);

    // APB decode; response is registered in the setup cycle so pready comes one cycle later
    wire       setup    = psel && !penable;
    wire       acc_wr   = psel && penable && pwrite && pready;
    wire       hit_mode = (paddr == ADDR_W'(`PMWS_MODE_ADDR));
    wire       hit_wd   = (paddr == ADDR_W'(`PMWS_WDCTL_ADDR));
    wire       hit_st   = (paddr == ADDR_W'(`PMWS_STAT_ADDR));
    wire [7:0] mode_rd  = {mode_reg[7:4], low_rdy, high_rdy, mode_reg[1:0]};
    wire [7:0] stat_rd  = {1'b0, 3'(state), 2'b00, tof, pd_flag};
    wire [31:0] rd_word = hit_mode ? {24'h000000, mode_rd} :
                          hit_wd   ? {24'h000000, wdctl_reg} :
                          hit_st   ? {24'h000000, stat_rd} : 32'h00000000;

    // APB response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            prdata  <= setup ? rd_word : prdata;
            pslverr <= setup && !(hit_mode || hit_wd || hit_st);
        end
    end

    // Software registers; ready bits are not stored here; held through every sleep mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg  <= `PMWS_MODE_RESET;
            wdctl_reg <= `PMWS_WDCTL_RESET;
        end else begin
            if (acc_wr && hit_mode) mode_reg <= pwdata[7:0] & 8'hf3;
            if (acc_wr && hit_wd)   wdctl_reg <= pwdata[7:0] & 8'h07;
        end
    end

    // Power-down and timeout flags; a same-cycle set beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_flag <= 1'b0;
            tof     <= 1'b0;
        end else begin
            pd_flag <= halt_take || (pd_flag && !wdt_clear_req);
            tof <= wdt_timeout || (tof && !wdt_clear_req && !halt_take);
        end
    end

    // Synchronisers for the wake pin and both oscillator ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_s1 <= 2'h0;
            tick_s2 <= 2'h0;
            tick_d  <= 2'h0;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            tick_s1 <= {low_osc_tick, high_osc_tick};
            tick_s2 <= tick_s1;
            tick_d  <= tick_s2;
            wake_s1 <= wake_pin;
            wake_s2 <= wake_s1;
        end
    end

    // Stabilisation counters; a stopped oscillator loses its ready flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_cnt <= 11'h000;
            low_cnt  <= 11'h000;
            high_rdy <= 1'b0;
            low_rdy  <= 1'b0;
        end else begin
            if (!high_osc_en) begin
                high_cnt <= 11'h000;
                high_rdy <= 1'b0;
            end else if (!high_rdy && high_tick) begin
                high_cnt <= high_cnt + 11'h001;
                high_rdy <= (high_cnt + 11'h001) >= high_limit;
            end
            if (!low_osc_en) begin
                low_cnt <= 11'h000;
                low_rdy <= 1'b0;
            end else if (!low_rdy && low_tick) begin
                low_cnt <= low_cnt + 11'h001;
                low_rdy <= (low_cnt + 11'h001) >= low_limit;
            end
        end
    end

    // Sequencer state, fast start tick count and restart length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= PMWS_RUN;
            fast_cnt    <= 2'h0;
            short_start <= 1'b0;
        end else begin
            state    <= next_state;
            fast_cnt <= (state != PMWS_FSTART) ? 2'h0 : (fast_cnt + {1'b0, low_tick});
            if (halt_take) short_start <= idle_sel;
            else if (state == PMWS_RUN && sys_rdy) short_start <= 1'b0;
        end
    end

    // Clock switch: gate off, change select while dark, then gate on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_src      <= PMWS_SRC_HIGH;
            clk_div      <= 3'h0;
            sys_clk_gate <= 1'b0;
        end else if (clk_move) begin
            sys_clk_gate <= 1'b0;
            if (!sys_clk_gate) begin
                clk_src <= tgt_src;
                clk_div <= tgt_div;
            end
        end else begin
            sys_clk_gate <= clk_on && ((clk_src == PMWS_SRC_LOW) ? low_rdy : high_rdy);
        end
    end

    // Oscillator, peripheral, watchdog and core controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_osc_en       <= 1'b1;
            low_osc_en        <= 1'b1;
            periph_div_clk_en <= 1'b0;
            time_base_clk_en  <= 1'b1;
            wdt_run           <= 1'b0;
            wdt_clear         <= 1'b0;
            cpu_halt          <= 1'b0;
            pwr_state         <= PMWS_RUN;
        end else begin
            high_osc_en       <= need_high;
            low_osc_en        <= need_low;
            periph_div_clk_en <= need_high && high_rdy;
            time_base_clk_en  <= (state != PMWS_SLEEP_DEEP) && (state != PMWS_SLEEP_SUB);
            wdt_run           <= wdt_en && (state != PMWS_SLEEP_DEEP)
                                 && (WDT_FROM_SUB || !asleep || state == PMWS_IDLE_RUN);
            wdt_clear         <= halt_take;
            cpu_halt          <= asleep || (state == PMWS_WAKE)
                                 || (state == PMWS_FSTART) || halt_take;
            pwr_state         <= state;
        end
    end
endmodule : pmws_top

`default_nettype wire

// File: tb/pmws_top_bench.sv
// Bench for the power mode sequencer: register access, run-mode switching, halt modes and wake-up paths.
// Assumes the default build: crystal high oscillator, low internal RC, sub-clocked watchdog.
`timescale 1ns/10ps
`default_nettype none

module pmws_top_bench;
    import pmws_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        halt_req, wdt_clear_req, wdt_timeout, wake_pin, high_osc_tick, low_osc_tick;
    logic        high_osc_en, low_osc_en, sys_clk_gate, periph_div_clk_en, time_base_clk_en;
    logic        wdt_run, wdt_clear, cpu_halt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [2:0]  clk_div;
    logic [3:0]  tcnt = '0;
    pmws_src_t   clk_src;
    pmws_state_t pwr_state;
    int          n_fail = 0, n_checks = 0, n_fast = 0, i, k, f0;
    // Halt cases: idle, keep, wdog, vdet, fast, fast expected, state
    logic [8:0]  cases [5] = '{9'b00001_0_011, 9'b00101_1_100, 9'b00010_0_100, 9'b10101_1_001, 9'b11000_0_010};

    pmws_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_req(halt_req), .wdt_clear_req(wdt_clear_req), .wdt_timeout(wdt_timeout), .wake_pin(wake_pin),
        .high_osc_tick(high_osc_tick), .low_osc_tick(low_osc_tick), .high_osc_en(high_osc_en),
        .low_osc_en(low_osc_en), .clk_src(clk_src), .clk_div(clk_div), .sys_clk_gate(sys_clk_gate),
        .periph_div_clk_en(periph_div_clk_en), .time_base_clk_en(time_base_clk_en), .wdt_run(wdt_run),
        .wdt_clear(wdt_clear), .cpu_halt(cpu_halt), .pwr_state(pwr_state));

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    // Oscillators only tick while enabled; short periods keep the 1024 counts cheap
    always @(posedge pclk) begin
        tcnt <= tcnt + 4'h1;
        high_osc_tick <= high_osc_en & tcnt[1];
        low_osc_tick <= low_osc_en & tcnt[2];
        if (pwr_state === PMWS_FAST) n_fast <= n_fast + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // A bound that ran out ends the run
    task automatic stop_if(input logic ok);
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR t=%0t wait ran out", $time);
            wrap_up();
        end
    endtask : stop_if

    // One transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        stop_if(pready === 1'b1);
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdata, err);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdata, err);
        check(rdata, exp);
    endtask : rd

    initial begin
        {psel, penable, pwrite, halt_req, wdt_clear_req, wdt_timeout, wake_pin} = '0;
        paddr = '0; pwdata = '0; presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values; ready flags may already be counting, so they are masked
        apb(1'b0, 12'h000, 32'h0, rdata, err); check(rdata & 32'hf3, 32'h03);
        rd(12'h004, 32'h00); rd(12'h008, 32'h00);
        apb(1'b0, 12'h00c, 32'h0, rdata, err); check(err, 1'b1); check(rdata, 32'h0);
        for (k = 0; k < 6000 && sys_clk_gate !== 1'b1; k++) @(posedge pclk);
        stop_if(sys_clk_gate === 1'b1);
        rd(12'h000, 32'h0f);
        // Low-speed run, then back through every high divider setting
        wr(12'h000, 32'h02);
        for (k = 0; k < 300 && !(clk_src === PMWS_SRC_LOW && sys_clk_gate === 1'b1); k++) @(posedge pclk);
        stop_if(clk_src === PMWS_SRC_LOW && sys_clk_gate === 1'b1);
        check(high_osc_en, 1'b0); check(periph_div_clk_en, 1'b0);
        wr(12'h000, 32'h03);
        for (k = 0; k < 6000 && !(clk_src === PMWS_SRC_HIGH && sys_clk_gate === 1'b1); k++) @(posedge pclk);
        stop_if(clk_src === PMWS_SRC_HIGH && sys_clk_gate === 1'b1);
        for (f0 = 2; f0 < 8; f0++) begin
            wr(12'h000, {24'h0, f0[2:0], 5'b00010});
            for (k = 0; k < 100 && !(clk_div === f0[2:0] && sys_clk_gate === 1'b1); k++) @(posedge pclk);
            check(clk_div, f0[2:0]); check(clk_src, PMWS_SRC_HIGH);
        end
        wr(12'h000, 32'h03);
        // Every halt mode, each woken again, with and without the fast path
        for (f0 = 0; f0 < 5; f0++) begin
            wr(12'h000, {27'h0, cases[f0][4], 2'b00, cases[f0][8], 1'b1});
            wr(12'h004, {29'h0, cases[f0][5], cases[f0][6], cases[f0][7]});
            wdt_timeout <= 1'b1;
            @(posedge pclk);
            wdt_timeout <= 1'b0;
            // Timeout flag must really be set before halt entry clears it
            rd(12'h008, 32'h02);
            halt_req <= 1'b1;
            @(posedge pclk);
            halt_req <= 1'b0;
            repeat (3) @(posedge pclk);
            check(pwr_state, cases[f0][2:0]);
            check(cpu_halt, 1'b1); check(wdt_run, cases[f0][6]);
            check(low_osc_en, cases[f0][8] | cases[f0][6] | cases[f0][5]);
            check(high_osc_en, cases[f0][7]);
            rd(12'h008, {25'h0, cases[f0][2:0], 4'h1});
            i = n_fast;
            k = i;
            wake_pin <= 1'b1;
            for (k = 0; k < 6000 && pwr_state !== PMWS_RUN; k++) @(posedge pclk);
            stop_if(pwr_state === PMWS_RUN);
            wake_pin <= 1'b0;
            for (k = 0; k < 50 && sys_clk_gate !== 1'b1; k++) @(posedge pclk);
            check(n_fast != i, cases[f0][3]);
            check(clk_src, PMWS_SRC_HIGH);
            wdt_clear_req <= 1'b1;
            @(posedge pclk);
            wdt_clear_req <= 1'b0;
        end
        wrap_up();
    end
endmodule : pmws_top_bench

`default_nettype wire

// File: tb/pmws_top_props.sv
// Port checker for the power mode sequencer: bus answer, halt entry, sleep clocks, clock switching.
// Assumes it is bound to pmws_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module pmws_top_props (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // Bus handshake
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pready,
    input  wire logic                  pslverr,
    // Core and clock controls
    input  wire logic                  halt_req,
    input  wire logic                  cpu_halt,
    input  wire logic                  wdt_clear,
    input  wire logic                  wdt_run,
    input  wire logic                  time_base_clk_en,
    input  wire logic                  sys_clk_gate,
    input  wire pmws_pkg::pmws_src_t   clk_src,
    input  wire logic [2:0]            clk_div,
    input  wire pmws_pkg::pmws_state_t pwr_state
);
    import pmws_pkg::*;
    // Single clock domain, so clock and reset are given once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Zero wait states, one-cycle answer
    chk_ready_zero_wait: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
    chk_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    // Halt entry: core stops and watchdog is cleared one cycle later
    chk_halt_entry: assert property (halt_req && !cpu_halt && pwr_state == PMWS_RUN |=> cpu_halt && wdt_clear)
        else $error("halt not taken");
    chk_clear_single: assert property (wdt_clear |=> !wdt_clear) else $error("clear pulse too long");
    // The core also runs in the fast-wake stage, then on the sub clock
    chk_halt_release: assert property ($fell(cpu_halt) |-> pwr_state == PMWS_RUN
        || (pwr_state == PMWS_FAST && clk_src == PMWS_SRC_LOW)) else $error("core freed early");
    // Clocks stopped in the two sleep modes
    chk_deep_clocks: assert property (pwr_state == PMWS_SLEEP_DEEP |-> !wdt_run && !time_base_clk_en && !sys_clk_gate)
        else $error("clock running in deep sleep");
    chk_sub_clocks: assert property (pwr_state == PMWS_SLEEP_SUB |-> !sys_clk_gate && !time_base_clk_en)
        else $error("clock running in sub sleep");
    // A select change only while the gate has been low for two cycles
    chk_switch_gated: assert property ((clk_src != $past(clk_src) || clk_div != $past(clk_div))
        |-> !sys_clk_gate && !$past(sys_clk_gate)) else $error("clock switched while gated on");

    cover_halt: cover property (halt_req && !cpu_halt ##1 cpu_halt);
    cover_fast: cover property (pwr_state == PMWS_FAST);
    cover_deep: cover property (pwr_state == PMWS_SLEEP_DEEP);
    cover_err: cover property (pslverr);
endmodule : pmws_top_props

bind pmws_top pmws_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .halt_req(halt_req), .cpu_halt(cpu_halt), .wdt_clear(wdt_clear),
    .wdt_run(wdt_run), .time_base_clk_en(time_base_clk_en), .sys_clk_gate(sys_clk_gate), .clk_src(clk_src),
    .clk_div(clk_div), .pwr_state(pwr_state));

`default_nettype wire
